// ===== hdl/lfn_pkg.sv
// Purpose: shared constants for the supply life notifier
// Assumes: 100 MHz clock, 0.1 s internal tick
// Notes: segment bytes are {dp,g,f,e,d,c,b,a}, digits left to right
package lfn_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_MS = 100;
   localparam int TICK_NS = TICK_MS * 1000000;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int TICKS_PER_S = 1000 / TICK_MS;

   localparam int POWERUP_MS = 200;
   localparam int POWERUP_TICKS = POWERUP_MS / TICK_MS;
   localparam int INIT_MS = 1000;
   localparam int INIT_TICKS = INIT_MS / TICK_MS;
   localparam int BOOT_ALARM_MS = 5000;
   localparam int BOOT_END_TICKS = (POWERUP_MS + BOOT_ALARM_MS) / TICK_MS;
   localparam int TEST_LONG_MS = 3000;
   localparam int TEST_LONG_TICKS = TEST_LONG_MS / TICK_MS;
   localparam int VER_MS = 500;
   localparam int VER_TICKS = VER_MS / TICK_MS;
   localparam int VER_REPEAT = 3;
   localparam int ALT_MS = 2000;
   localparam int ALT_TICKS = ALT_MS / TICK_MS;
   localparam int DOWN_BLANK_TICKS = 1;
   localparam int DOWN_PULSE_TICKS = 1;

   localparam int MONTH_S = 2592000;
   localparam int YEAR_S = 31536000;
   localparam int SIX_MONTH_S = YEAR_S / 2;
   localparam int TWO_YEAR_S = 2 * YEAR_S;
   localparam int HOT_LOCK_S = 3 * 3600;
   localparam int LIFE_S = 10 * YEAR_S;

   localparam logic [7:0] TEMP_BASE_C = 8'h28;
   localparam logic [7:0] TEMP_STEP_C = 8'h0a;

   localparam logic [7:0] SEG_DP = 8'h80;
   localparam logic [23:0] DISP_BLANK = 24'h000000;
   localparam logic [23:0] DISP_INIT = 24'h404040;
   localparam logic [23:0] DISP_FULL = 24'h713e38;
   localparam logic [23:0] DISP_HALF = 24'h763871;
   localparam logic [23:0] DISP_ALARM = 24'h773f5b;
   localparam logic [23:0] DISP_1P5 = 24'h866d00;
   localparam logic [23:0] DISP_0P5 = 24'hbf6d00;
   localparam logic [23:0] DISP_0P0 = 24'hbf3f00;
   localparam logic [23:0] DISP_HOT_ERR = 24'h765c7c;
   localparam logic [23:0] DISP_HOT_LOCK = 24'h765c78;
   localparam logic [23:0] DISP_FAULT = 24'h7f7f7f;

   typedef enum logic [2:0] {M_LOAD, M_INIT, M_RUN, M_DOWN, M_OFF} lfn_mode_e;
endpackage

// ===== hdl/lfn_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
module lfn_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } lfn_sync_s;
   lfn_sync_s st_r;
   lfn_sync_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // agree -> take stage three, else hold
      st_nxt.q = (st_r.s2 & st_r.s3) | (st_r.q & (st_r.s2 ^ st_r.s3));
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= {RST, RST, RST, RST};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.q;
endmodule

// ===== hdl/lfn_tick.sv
// Purpose: prescaled timebase, one-cycle tick every CYC clocks
// Assumes: en low stops and clears the prescaler
// Notes: cyc is a parameter so simulation can shorten it
`timescale 1ns/1ps
module lfn_tick #(
   parameter int CYC = lfn_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic en,
   output logic tick
);
   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } lfn_tick_s;
   lfn_tick_s st_r;
   lfn_tick_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (!en) begin
         st_nxt.cnt = 32'h0;
      end else if (st_r.cnt == 32'(CYC - 1)) begin
         st_nxt.cnt = 32'h0;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick = st_r.tick;
endmodule

// ===== hdl/lfn_notifier.sv
// Purpose: capacitor wear estimate, three-digit display and alarm output
// Assumes: reset follows supply power-up; wear restored from a store
// Notes: alarm_out high means output conducting (healthy)
`timescale 1ns/1ps
module lfn_notifier #(
   parameter int TICK_CYCLES = lfn_pkg::TICK_CYCLES,
   parameter int MONTH_S = lfn_pkg::MONTH_S,
   parameter int SIX_MONTH_S = lfn_pkg::SIX_MONTH_S,
   parameter int YEAR_S = lfn_pkg::YEAR_S,
   parameter int TWO_YEAR_S = lfn_pkg::TWO_YEAR_S,
   parameter int LIFE_S = lfn_pkg::LIFE_S,
   parameter int HOT_LOCK_S = lfn_pkg::HOT_LOCK_S,
   // arbitrary version pattern, shows "1.0"
   parameter logic [23:0] VERSION_DISP = 24'h863f00
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic power_good,
   input wire logic test_n,
   input wire logic overheat,
   input wire logic sys_fault,
   input wire logic [7:0] temp_c,
   input wire logic [39:0] nv_wear,
   input wire logic [31:0] nv_op_s,
   output logic [7:0] seg_left,
   output logic [7:0] seg_mid,
   output logic [7:0] seg_right,
   output logic alarm_out,
   output logic [39:0] wear_out,
   output logic [31:0] op_s_out
);
   typedef struct packed {
      lfn_pkg::lfn_mode_e mode;
      logic [3:0] sub;
      logic [31:0] op_s;
      logic [39:0] wear;
      logic [7:0] seq;
      logic due_boot;
      logic [4:0] alt;
      logic alt_ph;
      logic [4:0] btn_t;
      logic [1:0] ver_cnt;
      logic [3:0] ver_t;
      logic [31:0] hot_s;
      logic hot_lock;
      logic fault;
      logic alarm;
      logic [23:0] disp;
   } lfn_state_s;

   lfn_state_s st_r;
   lfn_state_s st_nxt;
   logic pwr;
   logic test_s_n;
   logic hot_in;
   logic tick;
   logic tick_en;
   logic [39:0] remain;
   logic due;
   logic young;
   logic sec;
   logic btn_long;
   logic [5:0] weight;
   logic [23:0] run_disp;
   logic run_alarm;

   lfn_sync #(.W(3), .RST(3'b110)) u_sync (
      .clk(clk),
      .resetn(resetn),
      .d({power_good, test_n, overheat}),
      .q({pwr, test_s_n, hot_in})
   );

   // timebase idles once the supply is fully down
   assign tick_en = (st_r.mode != lfn_pkg::M_OFF);

   lfn_tick #(.CYC(TICK_CYCLES)) u_tick (
      .clk(clk),
      .resetn(resetn),
      .en(tick_en),
      .tick(tick)
   );

   always_comb begin
      st_nxt = st_r;
      remain = (st_r.wear >= 40'(LIFE_S)) ? 40'h0 : 40'(LIFE_S) - st_r.wear;
      due = (remain <= 40'(SIX_MONTH_S));
      young = (st_r.op_s < 32'(MONTH_S));
      sec = tick && (st_r.sub == 4'(lfn_pkg::TICKS_PER_S - 1));
      btn_long = !test_s_n && (st_r.btn_t >= 5'(lfn_pkg::TEST_LONG_TICKS));
      // wear doubles per 10 degrees above base, held at eight times from base plus 30 up
      if (temp_c >= lfn_pkg::TEMP_BASE_C + 8'(3) * lfn_pkg::TEMP_STEP_C) begin
         weight = 6'h08;
      end else if (temp_c >= lfn_pkg::TEMP_BASE_C + 8'(2) * lfn_pkg::TEMP_STEP_C) begin
         weight = 6'h04;
      end else if (temp_c >= lfn_pkg::TEMP_BASE_C + lfn_pkg::TEMP_STEP_C) begin
         weight = 6'h02;
      end else begin
         weight = 6'h01;
      end

      if (tick) begin
         st_nxt.sub = sec ? 4'h0 : st_r.sub + 4'h1;
         if (st_r.seq != 8'hff) begin
            st_nxt.seq = st_r.seq + 8'h01;
         end
         if (st_r.alt == 5'(lfn_pkg::ALT_TICKS - 1)) begin
            st_nxt.alt = 5'h0;
            st_nxt.alt_ph = !st_r.alt_ph;
         end else begin
            st_nxt.alt = st_r.alt + 5'h1;
         end
      end

      // accrual only with power present
      if (sec && pwr && (st_r.mode == lfn_pkg::M_INIT || st_r.mode == lfn_pkg::M_RUN)) begin
         st_nxt.op_s = st_r.op_s + 32'h1;
         st_nxt.wear = st_r.wear + 40'(weight);
      end

      // button: short release starts version display
      if (!test_s_n) begin
         if (tick && st_r.btn_t < 5'(lfn_pkg::TEST_LONG_TICKS)) begin
            st_nxt.btn_t = st_r.btn_t + 5'h1;
         end
      end else begin
         if (st_r.btn_t != 5'h0 && st_r.btn_t < 5'(lfn_pkg::TEST_LONG_TICKS)) begin
            st_nxt.ver_cnt = 2'(lfn_pkg::VER_REPEAT);
            st_nxt.ver_t = 4'hf; // wraps to zero on next tick, so every showing is whole
         end
         st_nxt.btn_t = 5'h0;
      end
      if (st_r.ver_cnt != 2'h0 && tick) begin
         if (st_r.ver_t == 4'(2 * lfn_pkg::VER_TICKS - 1)) begin
            st_nxt.ver_t = 4'h0;
            st_nxt.ver_cnt = st_r.ver_cnt - 2'h1;
         end else begin
            st_nxt.ver_t = st_r.ver_t + 4'h1;
         end
      end

      // overheat lasting too long locks notification out
      if (!hot_in) begin
         st_nxt.hot_s = 32'h0;
      end else if (sec && !st_r.hot_lock) begin
         st_nxt.hot_s = st_r.hot_s + 32'h1;
         if (st_r.hot_s + 32'h1 >= 32'(HOT_LOCK_S)) begin
            st_nxt.hot_lock = 1'b1;
         end
      end
      if (sys_fault) begin
         st_nxt.fault = 1'b1;
      end

      // normal notification picture
      if (young) begin
         run_disp = lfn_pkg::DISP_FULL;
         run_alarm = 1'b1;
      end else if (due) begin
         run_disp = st_r.alt_ph ? lfn_pkg::DISP_ALARM : lfn_pkg::DISP_0P0;
         run_alarm = 1'b0;
      end else if (remain < 40'(YEAR_S)) begin
         run_disp = lfn_pkg::DISP_0P5;
         run_alarm = 1'b1;
      end else if (remain < 40'(TWO_YEAR_S)) begin
         run_disp = lfn_pkg::DISP_1P5;
         run_alarm = 1'b1;
      end else if (remain < 40'(LIFE_S / 2)) begin
         run_disp = lfn_pkg::DISP_HALF;
         run_alarm = 1'b1;
      end else begin
         run_disp = lfn_pkg::DISP_FULL;
         run_alarm = 1'b1;
      end
      if (st_r.due_boot && st_r.seq < 8'(lfn_pkg::BOOT_END_TICKS)) begin
         run_alarm = 1'b1;
      end
      // error and test overrides, highest first
      if (st_r.fault) begin
         run_disp = lfn_pkg::DISP_FAULT;
         run_alarm = 1'b0;
      end else if (st_r.hot_lock) begin
         run_disp = lfn_pkg::DISP_HOT_LOCK;
         run_alarm = 1'b0;
      end else if (hot_in) begin
         run_disp = lfn_pkg::DISP_HOT_ERR;
         run_alarm = 1'b0;
      end else if (btn_long) begin
         run_disp = lfn_pkg::DISP_ALARM;
         run_alarm = 1'b0;
      end else if (st_r.ver_cnt != 2'h0) begin
         run_disp = (st_r.ver_t < 4'(lfn_pkg::VER_TICKS)) ? VERSION_DISP : lfn_pkg::DISP_BLANK;
      end

      unique case (st_r.mode)
         lfn_pkg::M_LOAD: begin
            // stored wear taken after reset release, never under reset
            st_nxt.wear = nv_wear;
            st_nxt.op_s = nv_op_s;
            st_nxt.seq = 8'h0;
            st_nxt.mode = lfn_pkg::M_INIT;
            st_nxt.disp = lfn_pkg::DISP_BLANK;
            st_nxt.alarm = 1'b0;
         end
         lfn_pkg::M_INIT: begin
            st_nxt.disp = lfn_pkg::DISP_INIT;
            st_nxt.alarm = (st_r.seq >= 8'(lfn_pkg::POWERUP_TICKS)) && !st_r.hot_lock;
            st_nxt.due_boot = due && !young;
            if (tick && st_r.seq >= 8'(lfn_pkg::INIT_TICKS - 1)) begin
               st_nxt.mode = lfn_pkg::M_RUN;
            end
         end
         lfn_pkg::M_RUN: begin
            st_nxt.disp = run_disp;
            st_nxt.alarm = run_alarm;
         end
         lfn_pkg::M_DOWN: begin
            st_nxt.disp = lfn_pkg::DISP_BLANK;
            if (st_r.seq < 8'(lfn_pkg::DOWN_BLANK_TICKS)) begin
               st_nxt.alarm = st_r.alarm;
            end else begin
               // due unit gives one short pulse as it dies
               st_nxt.alarm = due && !young && (st_r.seq < 8'(lfn_pkg::DOWN_BLANK_TICKS
                  + lfn_pkg::DOWN_PULSE_TICKS));
            end
            if (st_r.seq >= 8'(lfn_pkg::DOWN_BLANK_TICKS + lfn_pkg::DOWN_PULSE_TICKS)) begin
               st_nxt.mode = lfn_pkg::M_OFF;
               st_nxt.alarm = 1'b0;
            end
         end
         lfn_pkg::M_OFF: begin
            st_nxt.disp = lfn_pkg::DISP_BLANK;
            st_nxt.alarm = 1'b0;
            if (pwr) begin
               st_nxt.mode = lfn_pkg::M_INIT;
               st_nxt.seq = 8'h0;
            end
         end
      endcase

      if (!pwr && (st_r.mode == lfn_pkg::M_INIT || st_r.mode == lfn_pkg::M_RUN)) begin
         st_nxt.mode = lfn_pkg::M_DOWN;
         st_nxt.seq = 8'h0;
         st_nxt.disp = lfn_pkg::DISP_BLANK;
         st_nxt.alarm = st_r.alarm;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign seg_left = st_r.disp[23:16];
   assign seg_mid = st_r.disp[15:8];
   assign seg_right = st_r.disp[7:0];
   assign alarm_out = st_r.alarm;
   assign wear_out = st_r.wear;
   assign op_s_out = st_r.op_s;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_long_press;
      st_r.mode == lfn_pkg::M_RUN && btn_long && !st_r.fault && !st_r.hot_lock && !hot_in && pwr;
   endsequence
   sequence s_forced_off;
      !alarm_out && st_r.disp == lfn_pkg::DISP_ALARM;
   endsequence

   property p_long_press;
      s_long_press |=> s_forced_off;
   endproperty
   a_long_press: assert property (p_long_press) else $error("long press not forcing alarm");

   property p_fault_off;
      st_r.fault && st_r.mode == lfn_pkg::M_RUN && pwr |=>
         !alarm_out && st_r.disp == lfn_pkg::DISP_FAULT;
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("fault not shown");

   property p_fault_sticky;
      st_r.fault |=> st_r.fault;
   endproperty
   a_fault_sticky: assert property (p_fault_sticky) else $error("fault cleared");

   property p_hot_lock;
      st_r.hot_lock |=> st_r.hot_lock && !alarm_out;
   endproperty
   a_hot_lock: assert property (p_hot_lock) else $error("hot lock lost");

   property p_hot_err;
      st_r.mode == lfn_pkg::M_RUN && pwr && hot_in && !st_r.fault && !st_r.hot_lock |=>
         st_r.disp == lfn_pkg::DISP_HOT_ERR && !alarm_out;
   endproperty
   a_hot_err: assert property (p_hot_err) else $error("overheat not shown");

   property p_young;
      st_r.mode == lfn_pkg::M_RUN && pwr && young && !hot_in && !st_r.fault && !st_r.hot_lock
         && !btn_long && st_r.ver_cnt == 2'h0 |=> alarm_out && st_r.disp == lfn_pkg::DISP_FULL;
   endproperty
   a_young: assert property (p_young) else $error("first month not full life");

   property p_powerup;
      st_r.mode == lfn_pkg::M_INIT && pwr && st_r.seq < 8'(lfn_pkg::POWERUP_TICKS) |=> !alarm_out;
   endproperty
   a_powerup: assert property (p_powerup) else $error("alarm on before 0.2 s");

   property p_down_blank;
      st_r.mode == lfn_pkg::M_DOWN |=> st_r.disp == lfn_pkg::DISP_BLANK;
   endproperty
   a_down_blank: assert property (p_down_blank) else $error("display lit at power-down");

   property p_no_count;
      !pwr && st_r.mode != lfn_pkg::M_LOAD |=> $stable(st_r.op_s) && $stable(st_r.wear);
   endproperty
   a_no_count: assert property (p_no_count) else $error("life counted unpowered");

   property p_due_alt;
      st_r.mode == lfn_pkg::M_RUN && pwr && due && !young && !hot_in && !st_r.fault
         && !st_r.hot_lock && !btn_long && st_r.ver_cnt == 2'h0
         && (!st_r.due_boot || st_r.seq >= 8'(lfn_pkg::BOOT_END_TICKS)) |=>
         !alarm_out && (st_r.disp == lfn_pkg::DISP_ALARM || st_r.disp == lfn_pkg::DISP_0P0);
   endproperty
   a_due_alt: assert property (p_due_alt) else $error("due picture wrong");
endmodule

// ===== tb/lfn_input_point.sv
// Purpose: model of the external input point that watches the alarm contact
// Assumes: contact high means the alarm output is conducting
// Notes: a startup mask hides the late rise of the contact after power-up
`timescale 1ns/1ps
module lfn_input_point #(
   parameter int MASK = 40,
   parameter int FILT = 5
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic contact,
   output logic replace_flag
);
   int mask_cnt;
   int off_cnt;
   // the contact closes only about 0.2 s after power-up, so ignore it until then
   // an open contact that stays open means replacement is due
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mask_cnt <= 0;
         off_cnt <= 0;
         replace_flag <= 1'b0;
      end else if (mask_cnt < MASK) begin
         mask_cnt <= mask_cnt + 1;
      end else begin
         off_cnt <= (contact === 1'b1) ? 0 : off_cnt + 1;
         replace_flag <= (off_cnt >= FILT);
      end
   end
endmodule

// ===== tb/tb.sv
// Purpose: self-checking bench for the supply life notifier
// Assumes: shortened counts, one tick is ten clocks, one second 100 clocks
// Notes: wear bands picked far from their edges so tick phase does not matter
`timescale 1ns/1ps
module tb;
   localparam int MON = 20;
   localparam int SIX = 40;
   localparam int YR = 80;
   localparam int TWO = 160;
   localparam int LIFE = 400;
   localparam logic [23:0] VER = 24'h863f00;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic power_good = 1'b1;
   logic test_n = 1'b1;
   logic overheat = 1'b0;
   logic sys_fault = 1'b0;
   logic [7:0] temp_c = 8'h1e;
   logic [39:0] nv_wear = 40'h0;
   logic [31:0] nv_op_s = 32'h0;
   logic [7:0] seg_left;
   logic [7:0] seg_mid;
   logic [7:0] seg_right;
   logic alarm_out;
   logic [39:0] wear_out;
   logic [31:0] op_s_out;
   logic flag;
   logic [23:0] disp;
   logic [23:0] last;
   logic [23:0] exp_d;
   logic [31:0] op_d;
   logic ab;
   int n_fail = 0;
   int cmp_count = 0;
   integer seed = 32'h2f10;
   int wt[6] = '{100, 220, 280, 340, 380, 380};
   int op0[6] = '{100, 100, 100, 100, 100, 0};
   int wgt;
   int tv;
   int t0;
   int nch;
   int ta;
   int tb_;
   assign disp = {seg_left, seg_mid, seg_right};
   always #5 clk = ~clk;
   lfn_notifier #(.TICK_CYCLES(10), .MONTH_S(MON), .SIX_MONTH_S(SIX), .YEAR_S(YR),
      .TWO_YEAR_S(TWO), .LIFE_S(LIFE), .HOT_LOCK_S(30), .VERSION_DISP(VER)) DUT (
      .clk(clk), .resetn(resetn), .power_good(power_good), .test_n(test_n),
      .overheat(overheat), .sys_fault(sys_fault), .temp_c(temp_c), .nv_wear(nv_wear),
      .nv_op_s(nv_op_s), .seg_left(seg_left), .seg_mid(seg_mid), .seg_right(seg_right),
      .alarm_out(alarm_out), .wear_out(wear_out), .op_s_out(op_s_out));
   lfn_input_point #(.MASK(40), .FILT(5)) u_point (
      .clk(clk), .resetn(resetn), .contact(alarm_out), .replace_flag(flag));
   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic boot(input logic [39:0] w, input logic [31:0] op, input logic [7:0] t);
      @(posedge clk);
      resetn <= 1'b0;
      nv_wear <= w;
      nv_op_s <= op;
      temp_c <= t;
      power_good <= 1'b1;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      #1;
   endtask
   function automatic logic [23:0] pic(input int w, input int op);
      int rem;
      rem = (w >= LIFE) ? 0 : LIFE - w;
      if (op < MON) return lfn_pkg::DISP_FULL;
      if (rem <= SIX) return lfn_pkg::DISP_0P0;
      if (rem < YR) return lfn_pkg::DISP_0P5;
      if (rem < TWO) return lfn_pkg::DISP_1P5;
      if (rem < LIFE / 2) return lfn_pkg::DISP_HALF;
      return lfn_pkg::DISP_FULL;
   endfunction
   task automatic conclude();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic power_off();
      logic pa;
      @(posedge clk);
      power_good <= 1'b0;
      ta = 0;
      tb_ = 0;
      pa = 1'b1;
      // ta counts alarm rises once the display is blank
      for (int k = 1; k <= 40; k++) begin
         cyc(1);
         if (tb_ == 0 && disp === lfn_pkg::DISP_BLANK) begin
            tb_ = k;
            ab = alarm_out;
         end
         if (tb_ > 0 && alarm_out === 1'b1 && pa !== 1'b1) ta++;
         pa = alarm_out;
      end
      chk(tb_ > 0 && alarm_out === 1'b0, "power-down picture");
   endtask
   initial begin
      #300000;
      n_fail++;
      conclude();
   end
   initial begin
      for (int i = 0; i < 6; i++) begin
         wgt = 1 << (i % 4);
         tv = (i % 4 == 0) ? 30 : 40 + 10 * (i % 4);
         boot(40'(wt[i]), 32'(op0[i]), 8'(tv + $unsigned($random(seed)) % 10));
         cyc(2);
         chk(disp === lfn_pkg::DISP_INIT && alarm_out === 1'b0, "initial display");
         cyc(10);
         chk(alarm_out === 1'b0, "alarm too early");
         cyc(30);
         chk(alarm_out === 1'b1, "alarm not on at 0.2 s");
         cyc(118);
         exp_d = pic(wt[i], op0[i]);
         chk(disp === exp_d || (exp_d === lfn_pkg::DISP_0P0 &&
            disp === lfn_pkg::DISP_ALARM), "life picture");
         chk(alarm_out === 1'b1, "alarm in boot window");
         op_d = op_s_out - 32'(op0[i]);
         chk(op_d >= 32'h1 && op_d <= 32'h2, "operating seconds");
         chk(wear_out - nv_wear === 40'(op_d * 32'(wgt)), "wear weight");
         if (i == 4) begin
            cyc(450);
            chk(alarm_out === 1'b0 && flag === 1'b1, "alarm off after boot");
            last = disp;
            nch = 0;
            for (int k = 1; k <= 600; k++) begin
               cyc(1);
               if (disp !== last) begin
                  if (nch > 0) chk(k - t0 == 200, "alternation period");
                  chk(disp === lfn_pkg::DISP_0P0 || disp === lfn_pkg::DISP_ALARM,
                     "alternation code");
                  nch++;
                  t0 = k;
                  last = disp;
               end
            end
            chk(nch >= 2, "no alternation");
            power_off();
            chk(ta == 1, "no pulse at power-down");
            op_d = op_s_out;
            cyc(300);
            chk(op_s_out === op_d, "count while off");
            @(posedge clk);
            power_good <= 1'b1;
            cyc(10);
            chk(disp === lfn_pkg::DISP_INIT, "power return");
         end
      end
      boot(40'h64, 32'h64, 8'h1e);
      cyc(160);
      @(posedge clk);
      test_n <= 1'b0;
      cyc(280);
      chk(disp === lfn_pkg::DISP_FULL && alarm_out === 1'b1, "press too soon");
      cyc(50);
      chk(disp === lfn_pkg::DISP_ALARM && alarm_out === 1'b0, "long press");
      @(posedge clk);
      test_n <= 1'b1;
      cyc(10);
      chk(disp === lfn_pkg::DISP_FULL && alarm_out === 1'b1, "press release");
      @(posedge clk);
      test_n <= 1'b0;
      cyc(100);
      @(posedge clk);
      test_n <= 1'b1;
      nch = 0;
      last = disp;
      for (int k = 1; k <= 400; k++) begin
         cyc(1);
         if (disp === VER && last !== VER) begin
            if (nch > 0) chk(k - t0 == 100, "version spacing");
            nch++;
            t0 = k;
         end
         last = disp;
      end
      chk(nch == 3 && disp === lfn_pkg::DISP_FULL, "version count");
      power_off();
      chk(ta == 0 && ab === 1'b1, "pulse when not due");
      @(posedge clk);
      power_good <= 1'b1;
      cyc(200);
      @(posedge clk);
      overheat <= 1'b1;
      cyc(20);
      chk(disp === lfn_pkg::DISP_HOT_ERR && alarm_out === 1'b0, "overheat");
      @(posedge clk);
      overheat <= 1'b0;
      cyc(20);
      chk(disp === lfn_pkg::DISP_FULL && alarm_out === 1'b1, "overheat cleared");
      @(posedge clk);
      overheat <= 1'b1;
      cyc(2850);
      chk(disp === lfn_pkg::DISP_HOT_ERR, "lock too early");
      cyc(250);
      @(posedge clk);
      overheat <= 1'b0;
      cyc(200);
      chk(disp === lfn_pkg::DISP_HOT_LOCK && alarm_out === 1'b0, "hot lock");
      boot(40'h64, 32'h64, 8'h1e);
      cyc(160);
      @(posedge clk);
      sys_fault <= 1'b1;
      @(posedge clk);
      sys_fault <= 1'b0;
      cyc(5);
      chk(disp === lfn_pkg::DISP_FAULT && alarm_out === 1'b0, "fault");
      cyc(300);
      chk(disp === lfn_pkg::DISP_FAULT && alarm_out === 1'b0, "fault held");
      conclude();
   end
endmodule
